//--- common/usb_rx_fifo_pkg.sv
package usb_rx_fifo_pkg;

   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_EPSEL      = 8'h01;
   localparam logic [7:0] IDX_DATA       = 8'h05;
   localparam logic [7:0] IDX_CNT_LOW    = 8'h06;
   localparam logic [7:0] IDX_CNT_HIGH   = 8'h07;
   localparam logic [7:0] IDX_CTRL       = 8'h08;
   localparam logic [7:0] IDX_FLAG       = 8'h09;
   localparam logic [7:0] IDX_FEAT       = 8'h0b;
   localparam logic [7:0] IDX_STATUS     = 8'h0c;
   localparam int         IDX_LSB        = 2;
   localparam int         IDX_W          = 8;
   localparam int         AXI_ADDR_W     = 12;

   // Control register layout
   localparam int         CTRL_FLUSH_BIT = 7;
   localparam int         CTRL_SIZE_LSB  = 5;
   localparam int         CTRL_ISO_BIT   = 3;
   localparam logic [7:0] CTRL_RESET     = 8'h04;
   localparam logic [7:0] CTRL_WMASK     = 8'hec;

   // Flag and status layout
   localparam int         FLAG_EMPTY_BIT = 3;
   localparam int         FLAG_FULL_BIT  = 2;
   localparam int         FLAG_OVF_BIT   = 0;
   localparam int         STAT_SETUP_BIT = 0;
   localparam int         STAT_TOGGLE_BIT = 7;

   // Byte count ring
   localparam int         COUNT_W        = 10;
   localparam int         COUNT_LOW_W    = 8;
   localparam int         RING_DEPTH     = 2;

   // AXI responses
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;

   // FIFO capacity in bytes
   localparam int         CAP_W          = 11;
   localparam logic [CAP_W-1:0] NISO_CAP [4] = '{11'h010, 11'h040, 11'h008, 11'h020};
   localparam logic [CAP_W-1:0] ISO_CAP  [4] = '{11'h040, 11'h100, 11'h200, 11'h400};
   localparam logic [CAP_W-1:0] CAP_64   = 11'h040;

   function automatic logic [CAP_W-1:0] fifo_cap(input logic [1:0] size,
                                                 input logic       iso,
                                                 input logic       feat);
      logic [CAP_W-1:0] c;
      c = iso ? ISO_CAP[size] : NISO_CAP[size];
      if (!iso && !feat && size[1]) begin
         c = CAP_64;
      end
      return c;
   endfunction : fifo_cap

endpackage : usb_rx_fifo_pkg

//--- common/reg_access_if.sv
`timescale 1ns/100ps
interface reg_access_if;
   logic       wr_en;
   logic [7:0] wr_index;
   logic [7:0] wdata;
   logic       wstrb0;
   logic       wr_hit;
   logic       rd_en;
   logic [7:0] rd_index;
   logic [7:0] rdata;
   logic       rd_hit;

   modport bus  (output wr_en, wr_index, wdata, wstrb0, rd_en, rd_index,
                 input  wr_hit, rdata, rd_hit);
   modport regs (input  wr_en, wr_index, wdata, wstrb0, rd_en, rd_index,
                 output wr_hit, rdata, rd_hit);
endinterface : reg_access_if

//--- rtl/axil_reg_slave.sv
`timescale 1ns/100ps
module axil_reg_slave
   import usb_rx_fifo_pkg::*;
#(
   parameter int ADDR_W = AXI_ADDR_W
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // Write channels
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // Read channels
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // Register side
   reg_access_if.bus              rb
);
   logic [IDX_W-1:0] aw_idx_reg, ar_idx_reg;
   logic [7:0]       wbyte_reg;
   logic             wstrb0_reg, rd_pend_reg;
   logic             awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0]       bresp_reg, rresp_reg;
   logic [31:0]      rdata_reg;

   // Outputs straight from flops
   assign awready     = awready_reg;
   assign wready      = wready_reg;
   assign bvalid      = bvalid_reg;
   assign bresp       = bresp_reg;
   assign arready     = arready_reg;
   assign rvalid      = rvalid_reg;
   assign rresp       = rresp_reg;
   assign rdata       = rdata_reg;

   // Register strobes, write once both halves are held
   assign rb.wr_en    = !awready_reg && !wready_reg && !bvalid_reg;
   assign rb.wr_index = aw_idx_reg;
   assign rb.wdata    = wbyte_reg;
   assign rb.wstrb0   = wstrb0_reg;
   assign rb.rd_en    = rd_pend_reg;
   assign rb.rd_index = ar_idx_reg;

   // Write path, address and data in either order
   always_ff @(posedge clk) begin
      if (reset) begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         aw_idx_reg  <= '0;
         wbyte_reg   <= '0;
         wstrb0_reg  <= 1'b0;
      end else begin
         if (awvalid && awready_reg) begin
            aw_idx_reg  <= awaddr[IDX_LSB +: IDX_W];
            awready_reg <= 1'b0;
         end
         if (wvalid && wready_reg) begin
            wbyte_reg  <= wdata[7:0];
            wstrb0_reg <= wstrb[0];
            wready_reg <= 1'b0;
         end
         if (rb.wr_en) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= rb.wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_reg && bready) begin
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
      end
   end

   // Read path, one register read strobe per request
   always_ff @(posedge clk) begin
      if (reset) begin
         arready_reg <= 1'b1;
         rd_pend_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= RESP_OKAY;
         rdata_reg   <= '0;
         ar_idx_reg  <= '0;
      end else begin
         if (arvalid && arready_reg) begin
            ar_idx_reg  <= araddr[IDX_LSB +: IDX_W];
            arready_reg <= 1'b0;
            rd_pend_reg <= 1'b1;
         end
         if (rd_pend_reg) begin
            rd_pend_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= {24'h000000, rb.rdata};
            rresp_reg   <= rb.rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (rvalid_reg && rready) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end
endmodule : axil_reg_slave

//--- rtl/byte_count_ring.sv
`timescale 1ns/100ps
module byte_count_ring
   import usb_rx_fifo_pkg::*;
#(
   parameter int W = COUNT_W
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // Control
   input  wire logic         clear,
   input  wire logic         push,
   input  wire logic [W-1:0] push_count,
   input  wire logic         pop,
   // Oldest stored count
   output logic [W-1:0]      count
);
   logic [W-1:0] entry_reg [RING_DEPTH];
   logic         wr_idx_reg, rd_idx_reg;
   logic [1:0]   level_reg;
   logic         do_push, do_pop;

   // Push when room, pop when not empty
   assign do_pop  = pop && (level_reg != 2'h0);
   assign do_push = push && ((level_reg != 2'(RING_DEPTH)) || do_pop);
   assign count   = (level_reg != 2'h0) ? entry_reg[rd_idx_reg] : '0;

   // Ring storage and indices
   always_ff @(posedge clk) begin
      if (reset || clear) begin
         wr_idx_reg <= 1'b0;
         rd_idx_reg <= 1'b0;
         level_reg  <= 2'h0;
      end else begin
         if (do_push) begin
            entry_reg[wr_idx_reg] <= push_count;
            wr_idx_reg            <= !wr_idx_reg;
         end
         if (do_pop) begin
            rd_idx_reg <= !rd_idx_reg;
         end
         level_reg <= level_reg + 2'(do_push) - 2'(do_pop);
      end
   end

   property p_ring_fill;
      @(posedge clk) disable iff (reset)
      (push && !pop && !clear && level_reg == 2'h0)
         |=> (level_reg == 2'h1) && (count == $past(push_count));
   endproperty
   a_ring_fill: assert property (p_ring_fill)
      else $error("count ring did not store pushed count");
endmodule : byte_count_ring

//--- rtl/usb_endpoint_receive_fifo.sv
// Overview of operation
// - Each data port read of a non-empty selected endpoint FIFO that is not clearing returns its next byte and advances its read pointer; an empty one reads 00.
// - Each byte from the serial engine to a FIFO that is not full or clearing is stored there and advances the write pointer.
// - Every endpoint keeps received packet byte counts in a two-entry ring read via low and high registers.
// - A stored byte count is 10 bits, read-only, low register bits 7:0 and high register bits 1:0.
// - The upper six bits of the high count register read as zero and firmware writes zeros there.
// - Flush empties the FIFO, resets pointers and the ring, clears the overflow and SETUP flags and leaves only empty set.
// - The flush bit clears itself once the flush is done.
// - Flush leaves the data toggle bit unchanged.
// - A new SETUP packet clears that endpoint's FIFO automatically.
// - Control bits 6:5 pick the capacity, 16/64/8/32 bytes, or 64/256/512/1024 when isochronous, each capped at DEPTH bytes.
// - The endpoint indexed control register resets to only bit 2 set.
// - With the extended feature enable clear, non-isochronous codes 10 and 11 both give 64 bytes.
`timescale 1ns/100ps
module usb_endpoint_receive_fifo
   import usb_rx_fifo_pkg::*;
#(
   parameter int NUM_EP = 16,
   parameter int DEPTH  = 64,
   parameter int ADDR_W = AXI_ADDR_W
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      reset,
   // AXI4-Lite write
   input  wire logic [ADDR_W-1:0]         awaddr,
   input  wire logic                      awvalid,
   output logic                           awready,
   input  wire logic [31:0]               wdata,
   input  wire logic [3:0]                wstrb,
   input  wire logic                      wvalid,
   output logic                           wready,
   output logic [1:0]                     bresp,
   output logic                           bvalid,
   input  wire logic                      bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0]         araddr,
   input  wire logic                      arvalid,
   output logic                           arready,
   output logic [31:0]                    rdata,
   output logic [1:0]                     rresp,
   output logic                           rvalid,
   input  wire logic                      rready,
   // Serial engine byte writes
   input  wire logic                      sie_wr_valid,
   input  wire logic [$clog2(NUM_EP)-1:0] sie_wr_ep,
   input  wire logic [7:0]                sie_wr_data,
   // Serial engine packet byte counts
   input  wire logic                      sie_pkt_valid,
   input  wire logic [$clog2(NUM_EP)-1:0] sie_pkt_ep,
   input  wire logic [COUNT_W-1:0]        sie_pkt_count,
   // Serial engine SETUP arrival and data toggle
   input  wire logic                      sie_setup_valid,
   input  wire logic [$clog2(NUM_EP)-1:0] sie_setup_ep,
   input  wire logic                      sie_toggle_valid,
   input  wire logic [$clog2(NUM_EP)-1:0] sie_toggle_ep,
   input  wire logic                      sie_toggle_value
);
   localparam int EPW = $clog2(NUM_EP);
   localparam int PW  = $clog2(DEPTH);
   localparam int LW  = PW + 1;

   reg_access_if rb ();

   // Per endpoint state
   logic [PW-1:0]      wr_ptr_reg   [NUM_EP];
   logic [PW-1:0]      wr_ptr_next  [NUM_EP];
   logic [PW-1:0]      rd_ptr_reg   [NUM_EP];
   logic [PW-1:0]      rd_ptr_next  [NUM_EP];
   logic [LW-1:0]      level_reg    [NUM_EP];
   logic [LW-1:0]      level_next   [NUM_EP];
   logic [7:0]         ctrl_reg     [NUM_EP];
   logic [7:0]         ctrl_next    [NUM_EP];
   logic [CAP_W-1:0]   cap_ep       [NUM_EP];
   logic [COUNT_W-1:0] cnt_ep       [NUM_EP];
   logic [NUM_EP-1:0]  ovf_reg, ovf_next, setup_reg, setup_next, toggle_reg, toggle_next;
   logic [NUM_EP-1:0]  clear_ep, flush_ep, push_ep, pop_ep, full_ep, empty_ep;

   // Shared state
   logic [7:0]         mem [NUM_EP*DEPTH];
   logic [EPW-1:0]     ep_sel_reg;
   logic               feat_reg;

   // Decoded accesses
   logic               ctrl_wr, epsel_wr, feat_wr, data_rd, high_rd;
   logic               hit_w, hit_r;
   logic [7:0]         data_sel, flag_sel, stat_sel, rd_mux;
   logic [COUNT_W-1:0] cnt_sel;
   logic               push_any;
   logic [EPW+PW-1:0]  mem_waddr, mem_raddr;

   // Bus slave
   axil_reg_slave #(
      .ADDR_W (ADDR_W)
   ) u_bus (
      .clk     (clk),
      .reset   (reset),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .rb      (rb)
   );

   // Access decode, writes on the low byte lane only
   assign ctrl_wr  = rb.wr_en && rb.wstrb0 && (rb.wr_index == IDX_CTRL);
   assign epsel_wr = rb.wr_en && rb.wstrb0 && (rb.wr_index == IDX_EPSEL);
   assign feat_wr  = rb.wr_en && rb.wstrb0 && (rb.wr_index == IDX_FEAT);
   assign data_rd  = rb.rd_en && (rb.rd_index == IDX_DATA);
   assign high_rd  = rb.rd_en && (rb.rd_index == IDX_CNT_HIGH);

   // Mapped index check for both directions
   assign hit_w = (rb.wr_index == IDX_EPSEL)   || (rb.wr_index == IDX_DATA)   ||
                  (rb.wr_index == IDX_CNT_LOW) || (rb.wr_index == IDX_CNT_HIGH) ||
                  (rb.wr_index == IDX_CTRL)    || (rb.wr_index == IDX_FLAG)   ||
                  (rb.wr_index == IDX_FEAT)    || (rb.wr_index == IDX_STATUS);
   assign hit_r = (rb.rd_index == IDX_EPSEL)   || (rb.rd_index == IDX_DATA)   ||
                  (rb.rd_index == IDX_CNT_LOW) || (rb.rd_index == IDX_CNT_HIGH) ||
                  (rb.rd_index == IDX_CTRL)    || (rb.rd_index == IDX_FLAG)   ||
                  (rb.rd_index == IDX_FEAT)    || (rb.rd_index == IDX_STATUS);
   assign rb.wr_hit = hit_w;
   assign rb.rd_hit = hit_r;

   // Per endpoint FIFO control, count ring and flags
   for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
      logic sel, wr_me, setup_me;
      logic [CAP_W-1:0] cap_raw;
      assign sel         = (ep_sel_reg == EPW'(e));
      assign wr_me       = sie_wr_valid && (sie_wr_ep == EPW'(e));
      assign setup_me    = sie_setup_valid && (sie_setup_ep == EPW'(e));
      assign flush_ep[e] = ctrl_reg[e][CTRL_FLUSH_BIT];
      assign clear_ep[e] = flush_ep[e] || setup_me;
      assign cap_raw     = fifo_cap(ctrl_reg[e][CTRL_SIZE_LSB +: 2],
                                    ctrl_reg[e][CTRL_ISO_BIT], feat_reg);
      // Sizes beyond the per endpoint storage are capped
      assign cap_ep[e]   = (cap_raw > CAP_W'(DEPTH)) ? CAP_W'(DEPTH) : cap_raw;
      assign full_ep[e]  = CAP_W'(level_reg[e]) >= cap_ep[e];
      assign empty_ep[e] = (level_reg[e] == '0);
      assign push_ep[e]  = wr_me && !full_ep[e] && !clear_ep[e];
      assign pop_ep[e]   = data_rd && sel && !empty_ep[e] && !clear_ep[e];

      // Pointer and fill level update
      assign wr_ptr_next[e] = clear_ep[e] ? '0 : wr_ptr_reg[e] + PW'(push_ep[e]);
      assign rd_ptr_next[e] = clear_ep[e] ? '0 : rd_ptr_reg[e] + PW'(pop_ep[e]);
      assign level_next[e]  = clear_ep[e] ? '0 :
                              level_reg[e] + LW'(push_ep[e]) - LW'(pop_ep[e]);

      // Control write, flush bit drops after one flush cycle
      assign ctrl_next[e] = (ctrl_wr && sel) ? (rb.wdata & CTRL_WMASK) :
                            (ctrl_reg[e] & ~(8'h01 << CTRL_FLUSH_BIT));

      // Flags, a new SETUP wins over the flush clear, a new overflow does not
      assign ovf_next[e]    = (wr_me && full_ep[e] && !clear_ep[e]) ||
                              (ovf_reg[e] && !clear_ep[e]);
      assign setup_next[e]  = setup_me || (setup_reg[e] && !flush_ep[e]);
      assign toggle_next[e] = (sie_toggle_valid && sie_toggle_ep == EPW'(e)) ?
                              sie_toggle_value : toggle_reg[e];

      byte_count_ring #(
         .W (COUNT_W)
      ) u_ring (
         .clk        (clk),
         .reset      (reset),
         .clear      (clear_ep[e]),
         .push       (sie_pkt_valid && (sie_pkt_ep == EPW'(e))),
         .push_count (sie_pkt_count),
         .pop        (high_rd && sel),
         .count      (cnt_ep[e])
      );
   end

   // Endpoint state registers
   always_ff @(posedge clk) begin
      if (reset) begin
         wr_ptr_reg <= '{default: '0};
         rd_ptr_reg <= '{default: '0};
         level_reg  <= '{default: '0};
         ctrl_reg   <= '{default: CTRL_RESET};
         ovf_reg    <= '0;
         setup_reg  <= '0;
         toggle_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         level_reg  <= level_next;
         ctrl_reg   <= ctrl_next;
         ovf_reg    <= ovf_next;
         setup_reg  <= setup_next;
         toggle_reg <= toggle_next;
      end
   end

   // Endpoint select and feature enable
   always_ff @(posedge clk) begin
      if (reset) begin
         ep_sel_reg <= '0;
         feat_reg   <= 1'b0;
      end else begin
         if (epsel_wr) begin
            ep_sel_reg <= rb.wdata[EPW-1:0];
         end
         if (feat_wr) begin
            feat_reg <= rb.wdata[0];
         end
      end
   end

   // Packet byte storage
   assign push_any  = |push_ep;
   assign mem_waddr = {sie_wr_ep, wr_ptr_reg[sie_wr_ep]};
   assign mem_raddr = {ep_sel_reg, rd_ptr_reg[ep_sel_reg]};

   always_ff @(posedge clk) begin
      if (push_any) begin
         mem[mem_waddr] <= sie_wr_data;
      end
   end

   // Read data selection for the selected endpoint
   assign data_sel = empty_ep[ep_sel_reg] ? 8'h00 : mem[mem_raddr];
   assign cnt_sel  = cnt_ep[ep_sel_reg];
   assign flag_sel = (8'(empty_ep[ep_sel_reg]) << FLAG_EMPTY_BIT) |
                     (8'(full_ep[ep_sel_reg])  << FLAG_FULL_BIT)  |
                     (8'(ovf_reg[ep_sel_reg])  << FLAG_OVF_BIT);
   assign stat_sel = (8'(setup_reg[ep_sel_reg])  << STAT_SETUP_BIT) |
                     (8'(toggle_reg[ep_sel_reg]) << STAT_TOGGLE_BIT);
   assign rd_mux   = (rb.rd_index == IDX_DATA)     ? data_sel :
                     (rb.rd_index == IDX_CNT_LOW)  ? cnt_sel[COUNT_LOW_W-1:0] :
                     (rb.rd_index == IDX_CNT_HIGH) ?
                        {6'h00, cnt_sel[COUNT_W-1:COUNT_LOW_W]} :
                     (rb.rd_index == IDX_CTRL)     ? ctrl_reg[ep_sel_reg] :
                     (rb.rd_index == IDX_FLAG)     ? flag_sel :
                     (rb.rd_index == IDX_STATUS)   ? stat_sel :
                     (rb.rd_index == IDX_EPSEL)    ? 8'(ep_sel_reg) :
                     (rb.rd_index == IDX_FEAT)     ? 8'(feat_reg) : 8'h00;
   assign rb.rdata = rd_mux;

   // Checks on the selected endpoint and on the endpoints the serial engine addresses
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_read_advances;
      (data_rd && !empty_ep[ep_sel_reg] && !clear_ep[ep_sel_reg] && !epsel_wr)
         |=> rd_ptr_reg[ep_sel_reg] == $past(rd_ptr_reg[ep_sel_reg]) + PW'(1);
   endproperty
   a_read_advances: assert property (p_read_advances)
      else $error("data port read did not advance read pointer");

   property p_write_advances;
      (sie_wr_valid && !full_ep[sie_wr_ep] && !clear_ep[sie_wr_ep])
         |=> wr_ptr_reg[$past(sie_wr_ep)] == $past(wr_ptr_reg[sie_wr_ep]) + PW'(1);
   endproperty
   a_write_advances: assert property (p_write_advances)
      else $error("engine write did not advance write pointer");

   property p_high_zero;
      (rb.rd_en && rb.rd_index == IDX_CNT_HIGH) |-> (rb.rdata[7:2] == 6'h00);
   endproperty
   a_high_zero: assert property (p_high_zero)
      else $error("high count upper bits not zero");

   property p_flush_selfclear;
      (flush_ep[ep_sel_reg] && !ctrl_wr && !epsel_wr) |=> !flush_ep[ep_sel_reg];
   endproperty
   a_flush_selfclear: assert property (p_flush_selfclear)
      else $error("flush bit did not clear itself");

   property p_flush_empties;
      (flush_ep[ep_sel_reg] && !epsel_wr)
         |=> empty_ep[ep_sel_reg] && !ovf_reg[ep_sel_reg] && (cnt_sel == '0);
   endproperty
   a_flush_empties: assert property (p_flush_empties)
      else $error("flush left data, count or overflow flag");

   property p_flush_keeps_toggle;
      (flush_ep[ep_sel_reg] && !sie_toggle_valid && !epsel_wr)
         |=> toggle_reg[ep_sel_reg] == $past(toggle_reg[ep_sel_reg]);
   endproperty
   a_flush_keeps_toggle: assert property (p_flush_keeps_toggle)
      else $error("flush changed data toggle bit");

   property p_setup_clears;
      sie_setup_valid |=> (level_reg[$past(sie_setup_ep)] == '0) && setup_reg[$past(sie_setup_ep)];
   endproperty
   a_setup_clears: assert property (p_setup_clears)
      else $error("SETUP arrival did not clear endpoint FIFO");

   property p_narrow_sizes;
      (!feat_reg && !ctrl_reg[ep_sel_reg][CTRL_ISO_BIT] &&
       ctrl_reg[ep_sel_reg][CTRL_SIZE_LSB + 1]) |-> (cap_ep[ep_sel_reg] == CAP_64);
   endproperty
   a_narrow_sizes: assert property (p_narrow_sizes)
      else $error("size code not widened to 64 bytes");

   property p_level_bounded;
      CAP_W'(level_reg[ep_sel_reg]) <= CAP_W'(DEPTH);
   endproperty
   a_level_bounded: assert property (p_level_bounded)
      else $error("fill level above depth");

   property p_overflow_sets;
      (sie_wr_valid && full_ep[sie_wr_ep] && !clear_ep[sie_wr_ep]) |=> ovf_reg[$past(sie_wr_ep)];
   endproperty
   a_overflow_sets: assert property (p_overflow_sets)
      else $error("write to full FIFO not flagged");

   property p_ctrl_spare;
      (ctrl_reg[ep_sel_reg] & ~CTRL_WMASK) == 8'h00;
   endproperty
   a_ctrl_spare: assert property (p_ctrl_spare)
      else $error("control spare bits not zero");

   property p_flush_setup;
      (flush_ep[ep_sel_reg] && !sie_setup_valid && !epsel_wr) |=> !setup_reg[ep_sel_reg];
   endproperty
   a_flush_setup: assert property (p_flush_setup)
      else $error("flush left setup flag");

   property p_toggle_load;
      sie_toggle_valid |=> toggle_reg[$past(sie_toggle_ep)] == $past(sie_toggle_value);
   endproperty
   a_toggle_load: assert property (p_toggle_load)
      else $error("data toggle not loaded");
endmodule : usb_endpoint_receive_fifo

//--- bench/cpu_bus_model.sv
`timescale 1ns/100ps
module cpu_bus_model
   import usb_rx_fifo_pkg::*;
(
   // Clock
   input  wire logic                  clk,
   // Bus master side
   output logic [AXI_ADDR_W-1:0]      awaddr,
   output logic [AXI_ADDR_W-1:0]      araddr,
   output logic [31:0]                wdata,
   output logic [3:0]                 wstrb,
   output logic                       awvalid,
   output logic                       wvalid,
   output logic                       bready,
   output logic                       arvalid,
   output logic                       rready,
   input  wire logic                  awready,
   input  wire logic                  wready,
   input  wire logic                  bvalid,
   input  wire logic [1:0]            bresp,
   input  wire logic                  arready,
   input  wire logic                  rvalid,
   input  wire logic [31:0]           rdata,
   input  wire logic [1:0]            rresp
);
   // Idle bus at time zero
   initial begin
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
   end
   // One register write, upper bits kept zero
   task automatic wr(input logic [7:0] i, input logic [7:0] d, output logic [1:0] r);
      @(posedge clk);
      awaddr <= {2'h0, i, 2'h0};
      wdata <= {24'h0, d};
      wstrb <= 4'hf;
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      r = bresp;
   endtask : wr
   // One register read
   task automatic rd(input logic [7:0] i, output logic [7:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= {2'h0, i, 2'h0};
      {arvalid, rready} <= 2'h3;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata[7:0];
      r = rresp;
   endtask : rd
endmodule : cpu_bus_model

//--- bench/tb_usb_endpoint_receive_fifo.sv
`timescale 1ns/100ps
module tb_usb_endpoint_receive_fifo
   import usb_rx_fifo_pkg::*;
;
   logic clk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, sie_toggle_value;
   logic sie_wr_valid, sie_pkt_valid, sie_setup_valid, sie_toggle_valid;
   logic [AXI_ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, sie_wr_ep, sie_pkt_ep, sie_setup_ep, sie_toggle_ep;
   logic [1:0] bresp, rresp;
   logic [7:0] sie_wr_data;
   logic [COUNT_W-1:0] sie_pkt_count;
   int failures = 0;
   int samples_checked = 0;
   usb_endpoint_receive_fifo u_usb_endpoint_receive_fifo (.*);
   cpu_bus_model u_cpu_bus_model (.*);
   // Clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rc(input logic [7:0] i, input logic [7:0] e, input string n);
      logic [7:0] d;
      logic [1:0] r;
      u_cpu_bus_model.rd(i, d, r);
      chk(n, e, d);
      chk({n, "_resp"}, {6'h0, RESP_OKAY}, {6'h0, r});
   endtask : rc
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      logic [1:0] r;
      u_cpu_bus_model.wr(i, d, r);
      chk("bresp", {6'h0, RESP_OKAY}, {6'h0, r});
   endtask : wr
   // Engine pulse: 0 byte, 1 count, 2 setup, 3 toggle
   task automatic eng(input int k, input logic [3:0] ep, input logic [9:0] v);
      @(posedge clk);
      {sie_wr_valid, sie_pkt_valid, sie_setup_valid, sie_toggle_valid} <= 4'h8 >> k;
      {sie_wr_ep, sie_pkt_ep, sie_setup_ep, sie_toggle_ep} <= {4{ep}};
      {sie_wr_data, sie_pkt_count, sie_toggle_value} <= {v[7:0], v, v[0]};
      @(posedge clk);
      {sie_wr_valid, sie_pkt_valid, sie_setup_valid, sie_toggle_valid} <= 4'h0;
   endtask : eng
   task automatic t_reset();
      logic [7:0] d;
      logic [1:0] r;
      rc(IDX_CTRL, 8'h04, "ctrl");
      rc(IDX_CNT_HIGH, 8'h00, "cnt_high");
      u_cpu_bus_model.rd(8'h02, d, r);
      chk("unmapped_resp", {6'h0, RESP_SLVERR}, {6'h0, r});
   endtask : t_reset
   task automatic t_stream();
      for (int k = 0; k < 4; k++) eng(0, 4'h2, 10'(10'h10 + k));
      eng(0, 4'h3, 10'hee);
      wr(IDX_EPSEL, 8'h02);
      for (int k = 0; k < 4; k++) rc(IDX_DATA, 8'(8'h10 + k), "data");
      wr(IDX_EPSEL, 8'h03);
      rc(IDX_DATA, 8'hee, "data_ep3");
   endtask : t_stream
   task automatic t_count();
      eng(1, 4'h3, 10'h2a5);
      eng(1, 4'h3, 10'h013);
      rc(IDX_CNT_LOW, 8'ha5, "cnt_low");
      rc(IDX_CNT_HIGH, 8'h02, "cnt_high");
      rc(IDX_CNT_LOW, 8'h13, "cnt_low2");
   endtask : t_count
   task automatic t_size_flush_setup();
      wr(IDX_EPSEL, 8'h04);
      wr(IDX_CTRL, 8'h00);
      repeat (17) eng(0, 4'h4, 10'h0);
      rc(IDX_FLAG, 8'h05, "flag_16");
      wr(IDX_CTRL, 8'h40);
      rc(IDX_FLAG, 8'h01, "flag_64");
      wr(IDX_FEAT, 8'h01);
      rc(IDX_FLAG, 8'h05, "flag_8");
      eng(3, 4'h4, 10'h1);
      wr(IDX_CTRL, 8'hc0);
      rc(IDX_CTRL, 8'h40, "ctrl_flush");
      rc(IDX_FLAG, 8'h08, "flag_flush");
      rc(IDX_STATUS, 8'h80, "status_flush");
      eng(0, 4'h4, 10'h5);
      eng(2, 4'h4, 10'h0);
      rc(IDX_FLAG, 8'h08, "flag_setup");
      wr(IDX_CTRL, 8'h68);
      repeat (64) eng(0, 4'h4, 10'h0);
      rc(IDX_FLAG, 8'h04, "flag_iso");
   endtask : t_size_flush_setup
   // Main sequence
   initial begin
      reset <= 1'b1;
      {sie_wr_valid, sie_pkt_valid, sie_setup_valid, sie_toggle_valid} <= 4'h0;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_stream();
      t_count();
      t_size_flush_setup();
      tally_and_finish();
   end
   // Watchdog
   initial begin
      #80000;
      failures++;
      tally_and_finish();
   end
endmodule : tb_usb_endpoint_receive_fifo
